// ---- hw/aev_pkg.sv ----
// register map, field layout and timing of the alert and event-flag logic
// assumes one device clock at 50 MHz shared with the serial register front end
package aev_pkg;
  // ************************************************************
  // register map
  // ************************************************************
  localparam logic [7:0] ADDR_SCAN_CHANNEL_ENABLE = 8'h12;
  localparam logic [7:0] ADDR_ALERT_CHANNEL_MASK = 8'h14;
  localparam logic [7:0] ADDR_ALERT_SOURCE_SELECT = 8'h16;
  localparam logic [7:0] ADDR_ALERT_PIN_CONFIG = 8'h17;
  localparam logic [7:0] ADDR_EVENT_SUMMARY_FLAGS = 8'h18;
  localparam logic [7:0] ADDR_EVENT_HIGH_FLAGS = 8'h1a;
  localparam logic [7:0] ADDR_EVENT_LOW_FLAGS = 8'h1c;

  localparam logic [7:0] RESET_VALUE = 8'h00;
  localparam logic [7:0] READ_UNMAPPED = 8'h00;
  localparam int CHANNELS = 8;

  // ************************************************************
  // fields
  // ************************************************************
  localparam int NOTIFY_ON_INPUT_CRC_ERROR_BIT = 0;
  localparam int ALERT_DRIVE_BIT = 2;
  localparam int ALERT_LOGIC_LSB = 0;
  localparam logic [1:0] LOGIC_LEVEL_LOW = 2'h0;
  localparam logic [1:0] LOGIC_LEVEL_HIGH = 2'h1;
  localparam logic [1:0] LOGIC_PULSE_LOW = 2'h2;
  localparam logic [1:0] LOGIC_PULSE_HIGH = 2'h3;

  // ************************************************************
  // timing
  // ************************************************************
  localparam int CLOCK_MHZ = 50;
  localparam int ALERT_PULSE_NS = 1000;
  localparam int ALERT_PULSE_CYCLES = (ALERT_PULSE_NS * CLOCK_MHZ + 999) / 1000;
  localparam logic [7:0] PULSE_COUNT_LAST = 8'(ALERT_PULSE_CYCLES - 1);

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } aev_reg_req_type;

  typedef enum logic [0:0] {
    PULSE_IDLE,
    PULSE_ACTIVE
  } aev_pulse_state_type;
endpackage : aev_pkg

// ---- hw/aev_flag_bank.sv ----
// one sticky flag per channel, set by hardware, cleared by writing one
// assumes set and clear arrive on the device clock
`timescale 1ns/1ns
module aev_flag_bank
  import aev_pkg::*;
(
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic [7:0] set_i,
  input wire logic [7:0] clear_i,
  output logic [7:0] flags_o
);
  logic [7:0] next_flags;

  // ************************************************************
  // per-channel flags
  // ************************************************************
  genvar ch;
  generate
    for (ch = 0; ch < CHANNELS; ch++) begin : g_flag
      // a set in the clearing cycle survives
      always_comb begin
        next_flags[ch] = set_i[ch] | (flags_o[ch] & ~clear_i[ch]);
      end
    end
  endgenerate

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      flags_o <= RESET_VALUE;
    end else begin
      flags_o <= next_flags;
    end
  end
endmodule : aev_flag_bank

// ---- hw/aev_alert_event_control.sv ----
// alert and event-flag control: scan mask, channel flags, summary, alert pin
// assumes the serial front end issues one-cycle register strobes on clk_i,
// and the comparators and crc checker drive set pulses and a crc flag on clk_i
`timescale 1ns/1ns
module aev_alert_event_control
  import aev_pkg::*;
(
  input wire logic clk_i,
  input wire logic reset_i,
  input wire aev_reg_req_type reg_req_i,
  input wire logic [7:0] high_event_i,
  input wire logic [7:0] low_event_i,
  input wire logic input_crc_error_flag_i,
  output logic [7:0] reg_rdata_o,
  output logic [7:0] scan_channel_enable_mask_o,
  output logic alert_out_o,
  output logic alert_oe_n_o
);
  // ************************************************************
  // configuration registers
  // ************************************************************
  logic [7:0] notify_channel_mask;
  logic notify_on_input_crc_error;
  logic alert_drive;
  logic [1:0] alert_logic;
  logic [7:0] next_scan_mask;
  logic [7:0] next_notify_channel_mask;
  logic next_notify_on_input_crc_error;
  logic next_alert_drive;
  logic [1:0] next_alert_logic;

  always_comb begin
    next_scan_mask = scan_channel_enable_mask_o;
    next_notify_channel_mask = notify_channel_mask;
    next_notify_on_input_crc_error = notify_on_input_crc_error;
    next_alert_drive = alert_drive;
    next_alert_logic = alert_logic;
    if (reg_req_i.wr) begin
      unique case (reg_req_i.addr)
        ADDR_SCAN_CHANNEL_ENABLE: begin
          next_scan_mask = reg_req_i.wdata;
        end
        ADDR_ALERT_CHANNEL_MASK: begin
          next_notify_channel_mask = reg_req_i.wdata;
        end
        ADDR_ALERT_SOURCE_SELECT: begin
          next_notify_on_input_crc_error = reg_req_i.wdata[NOTIFY_ON_INPUT_CRC_ERROR_BIT];
        end
        ADDR_ALERT_PIN_CONFIG: begin
          next_alert_drive = reg_req_i.wdata[ALERT_DRIVE_BIT];
          next_alert_logic = reg_req_i.wdata[ALERT_LOGIC_LSB +: 2];
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      scan_channel_enable_mask_o <= RESET_VALUE;
      notify_channel_mask <= RESET_VALUE;
      notify_on_input_crc_error <= 1'b0;
      alert_drive <= 1'b0;
      alert_logic <= LOGIC_LEVEL_LOW;
    end else begin
      scan_channel_enable_mask_o <= next_scan_mask;
      notify_channel_mask <= next_notify_channel_mask;
      notify_on_input_crc_error <= next_notify_on_input_crc_error;
      alert_drive <= next_alert_drive;
      alert_logic <= next_alert_logic;
    end
  end

  // ************************************************************
  // event flags and summary
  // ************************************************************
  logic [7:0] high_clear;
  logic [7:0] low_clear;
  logic [7:0] high_flags;
  logic [7:0] low_flags;
  logic [7:0] event_summary;

  assign high_clear = (reg_req_i.wr && reg_req_i.addr == ADDR_EVENT_HIGH_FLAGS) ? reg_req_i.wdata : 8'h00;
  assign low_clear = (reg_req_i.wr && reg_req_i.addr == ADDR_EVENT_LOW_FLAGS) ? reg_req_i.wdata : 8'h00;

  aev_flag_bank u_high_flags (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .set_i(high_event_i),
    .clear_i(high_clear),
    .flags_o(high_flags)
  );

  aev_flag_bank u_low_flags (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .set_i(low_event_i),
    .clear_i(low_clear),
    .flags_o(low_flags)
  );

  // summary has no storage of its own, so a write to its address clears nothing
  assign event_summary = high_flags | low_flags;

  // ************************************************************
  // register readback
  // ************************************************************
  logic [7:0] read_value;
  logic [7:0] next_rdata;

  always_comb begin
    unique case (reg_req_i.addr)
      ADDR_SCAN_CHANNEL_ENABLE: read_value = scan_channel_enable_mask_o;
      ADDR_ALERT_CHANNEL_MASK: read_value = notify_channel_mask;
      ADDR_ALERT_SOURCE_SELECT: read_value = {7'h00, notify_on_input_crc_error};
      ADDR_ALERT_PIN_CONFIG: read_value = {5'h00, alert_drive, alert_logic};
      ADDR_EVENT_SUMMARY_FLAGS: read_value = event_summary;
      ADDR_EVENT_HIGH_FLAGS: read_value = high_flags;
      ADDR_EVENT_LOW_FLAGS: read_value = low_flags;
      default: read_value = READ_UNMAPPED;
    endcase
    next_rdata = reg_req_i.rd ? read_value : reg_rdata_o;
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      reg_rdata_o <= RESET_VALUE;
    end else begin
      reg_rdata_o <= next_rdata;
    end
  end

  // ************************************************************
  // alert sources
  // ************************************************************
  logic [7:0] masked_events;
  logic crc_source;
  logic alert_active;
  logic [7:0] masked_prev;
  logic crc_prev;
  logic new_event;

  assign masked_events = event_summary & notify_channel_mask;
  assign crc_source = notify_on_input_crc_error & input_crc_error_flag_i;
  assign alert_active = (|masked_events) | crc_source;
  // any masked bit newly rising, or a fresh enabled crc error, fires a pulse
  assign new_event = (|(masked_events & ~masked_prev)) | (crc_source & ~crc_prev);

  // ************************************************************
  // pulse timer
  // ************************************************************
  aev_pulse_state_type pulse_state;
  aev_pulse_state_type next_pulse_state;
  logic [7:0] pulse_count;
  logic [7:0] next_pulse_count;

  // a new event during a pulse is merged into it rather than queued
  always_comb begin
    next_pulse_state = pulse_state;
    next_pulse_count = pulse_count;
    unique case (pulse_state)
      PULSE_IDLE: begin
        if (new_event && alert_logic[1]) begin
          next_pulse_state = PULSE_ACTIVE;
          next_pulse_count = 8'h00;
        end
      end
      PULSE_ACTIVE: begin
        if (pulse_count == PULSE_COUNT_LAST) begin
          next_pulse_state = PULSE_IDLE;
        end else begin
          next_pulse_count = pulse_count + 8'h01;
        end
      end
    endcase
  end

  // ************************************************************
  // pin driver
  // ************************************************************
  logic next_level;
  logic next_oe_n;

  always_comb begin
    unique case (alert_logic)
      LOGIC_LEVEL_LOW: next_level = ~alert_active;
      LOGIC_LEVEL_HIGH: next_level = alert_active;
      LOGIC_PULSE_LOW: next_level = ~(pulse_state == PULSE_ACTIVE);
      LOGIC_PULSE_HIGH: next_level = (pulse_state == PULSE_ACTIVE);
    endcase
    // open drain releases for a high level and leaves it to the pull-up
    next_oe_n = alert_drive ? 1'b0 : next_level;
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      pulse_state <= PULSE_IDLE;
      pulse_count <= 8'h00;
      masked_prev <= 8'h00;
      crc_prev <= 1'b0;
      alert_out_o <= 1'b1;
      alert_oe_n_o <= 1'b1;
    end else begin
      pulse_state <= next_pulse_state;
      pulse_count <= next_pulse_count;
      masked_prev <= masked_events;
      crc_prev <= crc_source;
      alert_out_o <= next_level;
      alert_oe_n_o <= next_oe_n;
    end
  end
endmodule : aev_alert_event_control

// ---- bench/aev_props.sv ----
// checker for the alert and event-flag block
// sees only the top ports; shadows the alert config registers from writes
`timescale 1ns/1ns
module aev_props
  import aev_pkg::*;
(
  input wire logic clk_i,
  input wire logic reset_i,
  input wire aev_reg_req_type reg_req_i,
  input wire logic [7:0] high_event_i,
  input wire logic [7:0] low_event_i,
  input wire logic input_crc_error_flag_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic [7:0] scan_channel_enable_mask_o,
  input wire logic alert_out_o,
  input wire logic alert_oe_n_o
);
  logic [7:0] mask, age, lo_run, hi_run;
  logic [2:0] cfg;
  logic src, wcfg;
  assign wcfg = reg_req_i.wr && reg_req_i.addr == ADDR_ALERT_PIN_CONFIG;
  // age gates pulse checks so a mode switch edge is not taken for a pulse
  always_ff @(posedge clk_i) begin
    if (reg_req_i.wr && reg_req_i.addr == ADDR_ALERT_CHANNEL_MASK) mask <= reg_req_i.wdata;
    if (reg_req_i.wr && reg_req_i.addr == ADDR_ALERT_SOURCE_SELECT) src <= reg_req_i.wdata[0];
    if (wcfg) cfg <= reg_req_i.wdata[2:0];
    age <= wcfg ? 8'h00 : age + {7'h00, age != 8'hff};
    lo_run <= alert_out_o ? 8'h00 : lo_run + 8'h01;
    hi_run <= alert_out_o ? hi_run + 8'h01 : 8'h00;
    if (reset_i) begin
      mask <= 8'h00;
      src <= 1'b0;
      cfg <= 3'h0;
      age <= 8'h00;
      lo_run <= 8'h00;
      hi_run <= 8'h00;
    end
  end
  // ************
  // assertions
  // ************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);
  sequence s_ev_hi; high_event_i != 8'h00; endsequence
  sequence s_ev_lo; low_event_i != 8'h00; endsequence
  sequence s_rd_sum; reg_req_i.rd && reg_req_i.addr == ADDR_EVENT_SUMMARY_FLAGS; endsequence
  a_scan_write: assert property (reg_req_i.wr && reg_req_i.addr == ADDR_SCAN_CHANNEL_ENABLE |=>
    scan_channel_enable_mask_o == $past(reg_req_i.wdata)) else $error("scan mask write lost");
  a_scan_read: assert property (reg_req_i.rd && reg_req_i.addr == ADDR_SCAN_CHANNEL_ENABLE |=>
    reg_rdata_o == $past(scan_channel_enable_mask_o)) else $error("scan mask read wrong");
  a_summary_high: assert property (s_ev_hi ##1 s_rd_sum |=>
    (reg_rdata_o & $past(high_event_i, 2)) == $past(high_event_i, 2)) else $error("high event missing");
  a_summary_low: assert property (s_ev_lo ##1 s_rd_sum |=>
    (reg_rdata_o & $past(low_event_i, 2)) == $past(low_event_i, 2)) else $error("low event missing");
  a_push_pull: assert property (cfg[2] && $past(cfg[2]) |-> !alert_oe_n_o)
    else $error("push-pull not driving");
  a_open_drain: assert property (!cfg[2] && !$past(cfg[2]) |-> alert_oe_n_o == alert_out_o)
    else $error("open-drain drives high");
  a_crc_low: assert property ($past(src && input_crc_error_flag_i && cfg[1:0] == LOGIC_LEVEL_LOW) |->
    !alert_out_o) else $error("crc alert not low");
  a_crc_high: assert property ($past(src && input_crc_error_flag_i && cfg[1:0] == LOGIC_LEVEL_HIGH) |->
    alert_out_o) else $error("crc alert not high");
  a_masked_quiet: assert property ($past(cfg[1:0] == LOGIC_LEVEL_HIGH && mask == 8'h00 && !src) |->
    !alert_out_o) else $error("alert without source");
  a_pulse_low: assert property ($rose(alert_out_o) && cfg[1:0] == LOGIC_PULSE_LOW && age > 8'h04 |->
    lo_run == PULSE_COUNT_LAST + 8'h01) else $error("low pulse width wrong");
  a_pulse_high: assert property ($fell(alert_out_o) && cfg[1:0] == LOGIC_PULSE_HIGH && age > 8'h04 |->
    hi_run == PULSE_COUNT_LAST + 8'h01) else $error("high pulse width wrong");
endmodule : aev_props
bind aev_alert_event_control aev_props u_props (.clk_i(clk_i), .reset_i(reset_i), .reg_req_i(reg_req_i),
  .high_event_i(high_event_i), .low_event_i(low_event_i), .input_crc_error_flag_i(input_crc_error_flag_i),
  .reg_rdata_o(reg_rdata_o), .scan_channel_enable_mask_o(scan_channel_enable_mask_o),
  .alert_out_o(alert_out_o), .alert_oe_n_o(alert_oe_n_o));

// ---- bench/aev_host_model.sv ----
// host-side view of the alert line
// assumes an external pull-up on the line
`timescale 1ns/1ns
module aev_host_model (
  input wire logic alert_out_i,
  input wire logic alert_oe_n_i,
  output logic pin_level_o
);
  // a released line floats up to the pull-up
  assign pin_level_o = alert_oe_n_i ? 1'b1 : alert_out_i;
endmodule : aev_host_model

// ---- bench/tb.sv ----
// self-checking bench for the alert and event-flag block
// assumes the host model resolves the alert line
`timescale 1ns/1ns
module tb;
  import aev_pkg::*;
  logic clk_i = 1'b0;
  logic reset_i = 1'b1;
  aev_reg_req_type req = '0;
  logic [7:0] hi_ev = 8'h00, lo_ev = 8'h00, rdata, scan, n;
  logic crc = 1'b0;
  logic aout, aoe_n, pin;
  int miscompares = 0;
  int tests_run = 0;
  always #10 clk_i = ~clk_i;
  aev_alert_event_control dut (.clk_i(clk_i), .reset_i(reset_i), .reg_req_i(req), .high_event_i(hi_ev),
    .low_event_i(lo_ev), .input_crc_error_flag_i(crc), .reg_rdata_o(rdata),
    .scan_channel_enable_mask_o(scan), .alert_out_o(aout), .alert_oe_n_o(aoe_n));
  aev_host_model host (.alert_out_i(aout), .alert_oe_n_i(aoe_n), .pin_level_o(pin));
  task automatic check(input string what, input logic [7:0] seen, exp);
    tests_run++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic wr(input logic [7:0] a, d);
    @(posedge clk_i);
    req <= '{1'b1, 1'b0, a, d};
    @(posedge clk_i);
    req <= '0;
  endtask : wr
  // events raised just before a read drop with its strobe
  task automatic rd(input logic [7:0] a, exp);
    @(posedge clk_i);
    req <= '{1'b0, 1'b1, a, 8'h00};
    hi_ev <= 8'h00;
    lo_ev <= 8'h00;
    @(posedge clk_i);
    req <= '0;
    #1 check("rdata", rdata, exp);
  endtask : rd
  task automatic settle;
    repeat (2) @(posedge clk_i);
    #1;
  endtask : settle
  // ************
  // scenarios
  // ************
  task automatic t_regs;
    rd(ADDR_SCAN_CHANNEL_ENABLE, RESET_VALUE);
    rd(ADDR_ALERT_PIN_CONFIG, RESET_VALUE);
    wr(ADDR_SCAN_CHANNEL_ENABLE, 8'ha5);
    #1 check("scan", scan, 8'ha5);
    rd(ADDR_SCAN_CHANNEL_ENABLE, 8'ha5);
    wr(ADDR_ALERT_SOURCE_SELECT, 8'hfe);
    rd(ADDR_ALERT_SOURCE_SELECT, 8'h00);
    wr(ADDR_ALERT_PIN_CONFIG, 8'hf8);
    rd(ADDR_ALERT_PIN_CONFIG, 8'h00);
    wr(ADDR_EVENT_SUMMARY_FLAGS, 8'hff);
    rd(ADDR_EVENT_SUMMARY_FLAGS, 8'h00);
    rd(8'h13, READ_UNMAPPED);
    $display("regs done");
  endtask : t_regs
  task automatic t_flags;
    @(posedge clk_i);
    hi_ev <= 8'h81;
    lo_ev <= 8'h02;
    rd(ADDR_EVENT_SUMMARY_FLAGS, 8'h83);
    rd(ADDR_EVENT_HIGH_FLAGS, 8'h81);
    rd(ADDR_EVENT_LOW_FLAGS, 8'h02);
    wr(ADDR_EVENT_SUMMARY_FLAGS, 8'hff);
    rd(ADDR_EVENT_SUMMARY_FLAGS, 8'h83);
    wr(ADDR_EVENT_HIGH_FLAGS, 8'h01);
    wr(ADDR_EVENT_LOW_FLAGS, 8'h00);
    rd(ADDR_EVENT_HIGH_FLAGS, 8'h80);
    rd(ADDR_EVENT_SUMMARY_FLAGS, 8'h82);
    wr(ADDR_EVENT_HIGH_FLAGS, 8'hff);
    wr(ADDR_EVENT_LOW_FLAGS, 8'hff);
    rd(ADDR_EVENT_SUMMARY_FLAGS, 8'h00);
    $display("flags done");
  endtask : t_flags
  task automatic t_level;
    wr(ADDR_ALERT_PIN_CONFIG, 8'h05);
    @(posedge clk_i);
    hi_ev <= 8'h08;
    @(posedge clk_i);
    hi_ev <= 8'h00;
    settle();
    check("pin", 8'(pin), 8'h00);
    wr(ADDR_ALERT_CHANNEL_MASK, 8'h08);
    settle();
    check("pin", 8'(pin), 8'h01);
    check("oe_n", 8'(aoe_n), 8'h00);
    wr(ADDR_EVENT_HIGH_FLAGS, 8'h08);
    settle();
    check("pin", 8'(pin), 8'h00);
    wr(ADDR_ALERT_PIN_CONFIG, 8'h00);
    @(posedge clk_i);
    crc <= 1'b1;
    settle();
    check("pin", 8'(pin), 8'h01);
    wr(ADDR_ALERT_SOURCE_SELECT, 8'h01);
    settle();
    check("pin", 8'(pin), 8'h00);
    wr(ADDR_ALERT_PIN_CONFIG, 8'h05);
    settle();
    check("pin", 8'(pin), 8'h01);
    @(posedge clk_i);
    crc <= 1'b0;
    settle();
    check("pin", 8'(pin), 8'h00);
    $display("level done");
  endtask : t_level
  task automatic t_pulse;
    wr(ADDR_ALERT_CHANNEL_MASK, 8'hff);
    rd(ADDR_ALERT_CHANNEL_MASK, 8'hff);
    for (int m = 2; m < 4; m++) begin
      wr(ADDR_ALERT_PIN_CONFIG, {6'h01, m[1:0]});
      settle();
      @(posedge clk_i);
      hi_ev <= 8'h10;
      // a second bit rising mid-pulse must merge
      @(posedge clk_i);
      hi_ev <= 8'h20;
      @(posedge clk_i);
      hi_ev <= 8'h00;
      n = 8'h00;
      for (int i = 0; i < 100; i++) begin
        @(posedge clk_i);
        #1 n = n + 8'(pin == m[0]);
      end
      check("pulse", n, 8'(ALERT_PULSE_CYCLES));
      wr(ADDR_EVENT_HIGH_FLAGS, 8'h30);
    end
    $display("pulse done");
  endtask : t_pulse
  task automatic stop_test;
    $display("checks %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : stop_test
  initial begin
    repeat (3) @(posedge clk_i);
    reset_i <= 1'b0;
    t_regs();
    t_flags();
    t_level();
    t_pulse();
    stop_test();
  end
  // the scenarios need well under a thousand cycles
  initial begin
    #100000;
    miscompares++;
    stop_test();
  end
endmodule : tb
